/* File: verilog/tsq_sequencer.sv */
// Trigger sequencer: register file, clocking, step engine and pulse outputs.
// Assumes a plain register port on clk; trigger and source pins are asynchronous.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tsq_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire tsq_pkg::tsq_bus_req_t bus_req,
  output logic [15:0] read_data,
  input wire logic [15:0] trig_in,
  input wire logic [4:0] clk_src_pins,
  output logic [15:0] trig_out_r,
  output logic [3:0] compare_sync_r,
  output logic compare1_clk_r,
  output logic [3:0] irq_out_r,
  output logic step_irq_r,
  output logic wdt_irq_r
);
  import tsq_pkg::*;

  logic [15:0] ctrl_r;
  logic [4:0] bte_r;
  logic [3:0] setup_r;
  logic [15:0] tlim0_r;
  logic [15:0] tlim1_r;
  logic [15:0] clim0_r;
  logic [15:0] clim1_r;
  logic [15:0] cnt0_r;
  logic [15:0] cnt1_r;
  logic [15:0] rdata_r;
  logic [15:0] rd_nxt;
  logic rd_que_r;
  logic [7:0] q_data;
  logic [7:0] q_rd;
  logic [15:0] trig_s1_r;
  logic [15:0] trig_s2_r;
  logic [15:0] trig_s3_r;
  logic [4:0] src_s1_r;
  logic [4:0] src_s2_r;
  logic [4:0] src_s3_r;
  logic [15:0] edge_now;
  logic [15:0] edge_seen_r;
  logic [4:0] src_rise;
  logic src_tick;
  logic [4:0] div_cnt_r;
  logic mod_tick;
  tsq_state_t state_r;
  logic [3:0] pc_r;
  logic [3:0] pc_nxt;
  logic [3:0] op;
  logic [3:0] opt;
  logic exec_now;
  logic is_wait;
  logic wait_ok;
  logic loop_take;
  logic step_done;
  logic single;
  logic bte_locked;
  logic bcast_fire;
  logic [1:0] tmr_load;
  logic [1:0] tmr_done;
  logic [15:0] wdt_cnt_r;
  logic [15:0] wdt_lim;
  logic wdt_expire;
  logic [4:0] pw_len;
  logic [4:0] pw_cnt_r;
  logic [4:0] bc_cnt_r;
  logic wr_ctrl;
  logic wr_bte;
  logic wr_setup;
  logic wr_que;

  assign wr_ctrl = bus_req.we && bus_req.addr == REG_CTRL;
  assign wr_bte = bus_req.we && bus_req.addr == REG_BTE;
  assign wr_setup = bus_req.we && bus_req.addr == REG_SETUP;
  assign wr_que = bus_req.we && bus_req.addr[5:4] == QUE_PAGE;
  assign single = setup_r[SET_SINGLE];
  assign op = q_data[7:4];
  assign opt = q_data[3:0];
  assign pw_len = {1'b0, ctrl_r[PWD_HI:PWD_LO]} + 5'h01;
  assign wdt_lim = tsq_wdt_limit(ctrl_r[WDT_HI:WDT_LO]);

  // Locked only while truly running, so software can stage it when idle
  assign bte_locked = setup_r[SET_EN] && setup_r[SET_START]
    && state_r != ST_IDLE;

  // Register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= 16'h0000;
    end else if (wr_ctrl) begin
      ctrl_r <= bus_req.wdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bte_r <= 5'h00;
    end else if (wr_bte && !bte_locked) begin
      bte_r <= bus_req.wdata[4:0] & BTE_WMASK;
    end
  end

  // Hardware clears start after a single step or a watchdog abort;
  // a software write in the same cycle wins.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup_r <= 4'h0;
    end else if (wr_setup) begin
      setup_r <= bus_req.wdata[3:0] & SETUP_WMASK;
    end else if ((step_done && single) || wdt_expire) begin
      setup_r[SET_START] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tlim0_r <= 16'h0000;
      tlim1_r <= 16'h0000;
      clim0_r <= 16'h0000;
      clim1_r <= 16'h0000;
    end else if (bus_req.we) begin
      if (bus_req.addr == REG_TLIM0) tlim0_r <= bus_req.wdata;
      if (bus_req.addr == REG_TLIM1) tlim1_r <= bus_req.wdata;
      if (bus_req.addr == REG_CLIM0) clim0_r <= bus_req.wdata;
      if (bus_req.addr == REG_CLIM1) clim1_r <= bus_req.wdata;
    end
  end

  always_comb begin
    unique case (bus_req.addr)
      REG_CTRL: rd_nxt = ctrl_r;
      REG_BTE: rd_nxt = {11'h000, bte_r};
      REG_SETUP: rd_nxt = {12'h000, setup_r};
      REG_STAT: rd_nxt = {8'h00, pc_r, 1'b0, state_r, state_r != ST_IDLE};
      REG_TLIM0: rd_nxt = tlim0_r;
      REG_TLIM1: rd_nxt = tlim1_r;
      REG_CLIM0: rd_nxt = clim0_r;
      REG_CLIM1: rd_nxt = clim1_r;
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 16'h0000;
      rd_que_r <= 1'b0;
    end else begin
      rdata_r <= bus_req.re ? rd_nxt : 16'h0000;
      rd_que_r <= bus_req.re && bus_req.addr[5:4] == QUE_PAGE;
    end
  end

  assign read_data = rd_que_r ? {8'h00, q_rd} : rdata_r;

  tsq_queue_mem u_queue (
    .clk(clk),
    .sys_rst(sys_rst),
    .we(wr_que),
    .waddr(bus_req.addr[3:0]),
    .wdata(bus_req.wdata[7:0]),
    .a_addr(pc_r),
    .a_data_r(q_data),
    .b_addr(bus_req.addr[3:0]),
    .b_data_r(q_rd)
  );

  // Pin synchronisers; third stage only keeps the previous level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_s1_r <= 16'h0000;
      trig_s2_r <= 16'h0000;
      trig_s3_r <= 16'h0000;
      src_s1_r <= 5'h00;
      src_s2_r <= 5'h00;
      src_s3_r <= 5'h00;
    end else begin
      trig_s1_r <= trig_in;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      src_s1_r <= clk_src_pins;
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
    end
  end

  assign edge_now = setup_r[SET_FALL] ? (~trig_s2_r & trig_s3_r)
    : (trig_s2_r & ~trig_s3_r);
  assign src_rise = src_s2_r & ~src_s3_r;

  // Edges are caught between ticks so a slow module clock misses none
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edge_seen_r <= 16'h0000;
    end else if (state_r == ST_FETCH) begin
      edge_seen_r <= edge_now;
    end else begin
      edge_seen_r <= edge_seen_r | edge_now;
    end
  end

  // Module clock: source select then prescale
  always_comb begin
    unique case (ctrl_r[CLK_HI:CLK_LO])
      CLK_SYS: src_tick = 1'b1;
      CLK_RSVD6, CLK_RSVD7: src_tick = 1'b0;
      default: src_tick = src_rise[3'(ctrl_r[CLK_HI:CLK_LO] - 3'h1)];
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt_r <= 5'h00;
    end else if (src_tick) begin
      div_cnt_r <= (div_cnt_r >= ctrl_r[DIV_HI:DIV_LO]) ? 5'h00
        : div_cnt_r + 5'h01;
    end
  end

  assign mod_tick = src_tick && div_cnt_r >= ctrl_r[DIV_HI:DIV_LO];

  // Step decode
  assign exec_now = state_r == ST_EXEC && mod_tick;
  assign is_wait = op == OP_WAIT
    || (op == OP_CTRL && (opt == OPT_TMR0 || opt == OPT_TMR1));
  assign wait_ok = (op == OP_WAIT) ? edge_seen_r[opt] : tmr_done[opt[0]];
  assign loop_take = (op == OP_LOOP0 && cnt0_r != clim0_r)
    || (op == OP_LOOP1 && cnt1_r != clim1_r) || op == OP_JUMP;
  assign pc_nxt = loop_take ? opt : pc_r + 4'h1;
  assign step_done = (exec_now && !is_wait)
    || (state_r == ST_WAIT && mod_tick && wait_ok);
  assign bcast_fire = exec_now && op == OP_CTRL && opt == OPT_BCAST;
  assign tmr_load[0] = exec_now && op == OP_CTRL && opt == OPT_TMR0;
  assign tmr_load[1] = exec_now && op == OP_CTRL && opt == OPT_TMR1;
  assign wdt_expire = state_r == ST_WAIT && mod_tick && !wait_ok
    && ctrl_r[WDT_HI:WDT_LO] != WDT_OFF
    && wdt_cnt_r + 16'h0001 == wdt_lim;

  tsq_timer u_tmr0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(mod_tick),
    .load(tmr_load[0]),
    .limit(tlim0_r),
    .done_r(tmr_done[0])
  );

  tsq_timer u_tmr1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(mod_tick),
    .load(tmr_load[1]),
    .limit(tlim1_r),
    .done_r(tmr_done[1])
  );

  // Step engine
  always_ff @(posedge clk) begin
    if (sys_rst || !setup_r[SET_EN]) begin
      state_r <= ST_IDLE;
      pc_r <= 4'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: if (setup_r[SET_START]) state_r <= ST_FETCH;
        ST_FETCH: state_r <= ST_EXEC;
        ST_EXEC: begin
          if (mod_tick && is_wait) begin
            state_r <= ST_WAIT;
          end else if (mod_tick) begin
            pc_r <= pc_nxt;
            state_r <= single ? ST_IDLE : ST_FETCH;
          end
        end
        ST_WAIT: begin
          if (wdt_expire) begin
            state_r <= ST_IDLE;
          end else if (step_done) begin
            pc_r <= pc_r + 4'h1;
            state_r <= single ? ST_IDLE : ST_FETCH;
          end
        end
      endcase
    end
  end

  // Loop counters count passes, then clear and fall through
  always_ff @(posedge clk) begin
    if (sys_rst || !setup_r[SET_EN]) begin
      cnt0_r <= 16'h0000;
      cnt1_r <= 16'h0000;
    end else if (exec_now && op == OP_LOOP0) begin
      cnt0_r <= loop_take ? cnt0_r + 16'h0001 : 16'h0000;
    end else if (exec_now && op == OP_LOOP1) begin
      cnt1_r <= loop_take ? cnt1_r + 16'h0001 : 16'h0000;
    end
  end

  // Watchdog restarts every step
  always_ff @(posedge clk) begin
    if (sys_rst || state_r != ST_WAIT) begin
      wdt_cnt_r <= 16'h0000;
    end else if (mod_tick) begin
      wdt_cnt_r <= wdt_cnt_r + 16'h0001;
    end
  end

  // Trigger pulse; a new trigger step restarts the pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pw_cnt_r <= 5'h00;
      trig_out_r <= 16'h0000;
    end else if (exec_now && op == OP_TRIG) begin
      pw_cnt_r <= pw_len;
      trig_out_r <= tsq_onehot16(opt);
    end else if (mod_tick && pw_cnt_r != 5'h00) begin
      pw_cnt_r <= pw_cnt_r - 5'h01;
      if (pw_cnt_r == 5'h01) trig_out_r <= 16'h0000;
    end
  end

  // Broadcast sync outputs share the programmed width; the compare one clock is a single-cycle pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bc_cnt_r <= 5'h00;
      compare_sync_r <= 4'h0;
      compare1_clk_r <= 1'b0;
    end else begin
      compare1_clk_r <= bcast_fire && bte_r[BTE_C1CLK];
      if (bcast_fire) begin
        bc_cnt_r <= pw_len;
        compare_sync_r <= bte_r[3:0];
      end else if (mod_tick && bc_cnt_r != 5'h00) begin
        bc_cnt_r <= bc_cnt_r - 5'h01;
        if (bc_cnt_r == 5'h01) compare_sync_r <= 4'h0;
      end
    end
  end

  // Interrupt pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_out_r <= 4'h0;
      step_irq_r <= 1'b0;
      wdt_irq_r <= 1'b0;
    end else begin
      irq_out_r <= (exec_now && op == OP_IRQ)
        ? 4'(tsq_onehot16({2'h0, opt[1:0]})) : 4'h0;
      step_irq_r <= step_done && single;
      wdt_irq_r <= wdt_expire;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_bcast;
    bcast_fire ##1 compare1_clk_r;
  endsequence

  bte_lock_a: assert property (wr_bte && bte_locked |=> $stable(bte_r))
    else $error("broadcast enables changed while locked");
  ctrl_bit3_a: assert property (bus_req.re && bus_req.addr == REG_CTRL
    |=> !read_data[CTRL_RSVD])
    else $error("unimplemented control bit read as one");
  pulse_width_a: assert property (exec_now && op == OP_TRIG
    |=> pw_cnt_r == pw_len && trig_out_r != 16'h0000)
    else $error("trigger pulse not loaded with programmed width");
  wdt_abort_a: assert property (wdt_expire
    |=> wdt_irq_r && state_r == ST_IDLE && !setup_r[SET_START])
    else $error("watchdog time-out not reported");
  single_step_a: assert property (step_done && single && !wr_setup
    |=> step_irq_r && !setup_r[SET_START] ##1 !step_irq_r)
    else $error("single step interrupt missing");
  bcast_sync_a: assert property (bcast_fire
    |=> compare_sync_r == $past(bte_r[3:0]))
    else $error("broadcast sync pulses do not match enables");
  c1_clock_a: assert property (compare1_clk_r
    |-> $past(bcast_fire && bte_r[BTE_C1CLK]) ##1 !compare1_clk_r)
    else $error("compare one clock pulse wrong");
  bcast_seq_a: assert property (bte_r[BTE_C1CLK] && bcast_fire
    |-> s_bcast)
    else $error("broadcast step did not pulse compare one clock");
  irq_pulse_a: assert property (exec_now && op == OP_IRQ
    |=> irq_out_r == (4'h1 << $past(opt[1:0])) ##1 irq_out_r == 4'h0)
    else $error("step interrupt output wrong");
  rsvd_clock_a: assert property (ctrl_r[CLK_HI:CLK_LO] == CLK_RSVD6
    || ctrl_r[CLK_HI:CLK_LO] == CLK_RSVD7 |-> !mod_tick)
    else $error("reserved clock source produced a tick");
endmodule
`default_nettype wire

/* File: verilog/tsq_pkg.sv */
// Constants, types and helpers shared by the trigger sequencer files.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package tsq_pkg;
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_BTE = 6'h01;
  localparam logic [5:0] REG_SETUP = 6'h02;
  localparam logic [5:0] REG_STAT = 6'h03;
  localparam logic [5:0] REG_TLIM0 = 6'h04;
  localparam logic [5:0] REG_TLIM1 = 6'h05;
  localparam logic [5:0] REG_CLIM0 = 6'h06;
  localparam logic [5:0] REG_CLIM1 = 6'h07;
  localparam logic [1:0] QUE_PAGE = 2'h1;
  localparam logic [15:0] CTRL_WMASK = 16'hfff7;
  localparam logic [4:0] BTE_WMASK = 5'h1f;
  localparam int BTE_C1CLK = 4;
  localparam logic [3:0] SETUP_WMASK = 4'hf;
  localparam int SET_EN = 0;
  localparam int SET_START = 1;
  localparam int SET_FALL = 2;
  localparam int SET_SINGLE = 3;
  localparam int CLK_HI = 15;
  localparam int CLK_LO = 13;
  localparam int DIV_HI = 12;
  localparam int DIV_LO = 8;
  localparam int PWD_HI = 7;
  localparam int PWD_LO = 4;
  localparam int WDT_HI = 2;
  localparam int WDT_LO = 0;
  localparam int CTRL_RSVD = 3;
  localparam logic [2:0] CLK_SYS = 3'h0;
  localparam logic [2:0] CLK_RSVD6 = 3'h6;
  localparam logic [2:0] CLK_RSVD7 = 3'h7;
  localparam logic [2:0] WDT_OFF = 3'h0;
  localparam logic [15:0] WDT_UNIT = 16'h0004;
  localparam logic [3:0] OP_CTRL = 4'h0;
  localparam logic [3:0] OP_WAIT = 4'h1;
  localparam logic [3:0] OP_TRIG = 4'h2;
  localparam logic [3:0] OP_IRQ = 4'h3;
  localparam logic [3:0] OP_LOOP0 = 4'h4;
  localparam logic [3:0] OP_LOOP1 = 4'h5;
  localparam logic [3:0] OP_JUMP = 4'h6;
  localparam logic [3:0] OPT_TMR0 = 4'h8;
  localparam logic [3:0] OPT_TMR1 = 4'h9;
  localparam logic [3:0] OPT_BCAST = 4'hf;

  typedef struct packed {
    logic we;
    logic re;
    logic [5:0] addr;
    logic [15:0] wdata;
  } tsq_bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10,
    ST_WAIT = 2'b11
  } tsq_state_t;

  function automatic logic [15:0] tsq_wdt_limit(input logic [2:0] code);
    return WDT_UNIT << code;
  endfunction

  function automatic logic [15:0] tsq_onehot16(input logic [3:0] idx);
    return 16'h0001 << idx;
  endfunction
endpackage

/* File: verilog/tsq_queue_mem.sv */
// Sixteen-entry step queue, one write port and two registered read ports.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tsq_queue_mem (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] a_addr,
  output logic [7:0] a_data_r,
  input wire logic [3:0] b_addr,
  output logic [7:0] b_data_r
);
  logic [7:0] mem [16];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_data_r <= 8'h00;
      b_data_r <= 8'h00;
    end else begin
      a_data_r <= mem[a_addr];
      b_data_r <= mem[b_addr];
    end
  end
endmodule
`default_nettype wire

/* File: verilog/tsq_timer.sv */
// One 16-bit step timer counting module clock ticks up to a limit.
// Assumes load and tick are single-cycle strobes on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tsq_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [15:0] limit,
  output logic done_r
);
  logic [15:0] count_r;
  logic run_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= 16'h0000;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else if (load) begin
      count_r <= 16'h0000;
      run_r <= 1'b1;
      done_r <= 1'b0;
    end else if (tick && run_r) begin
      if (count_r == limit) begin
        run_r <= 1'b0;
        done_r <= 1'b1;
      end else begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  timer_done_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(done_r) |-> $past(run_r) && $past(count_r) == $past(limit))
    else $error("timer finished before reaching its limit");
endmodule
`default_nettype wire

/* File: sim/tsq_periph_model.sv */
// Far-side peripheral model: trigger sources and clock-source pins.
// Assumes the bench requests a pulse with a one-cycle go strobe on clk.
`timescale 1ns/100ps
`default_nettype none
module tsq_periph_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [3:0] idx,
  output logic [15:0] trig_in,
  output logic [4:0] clk_src_pins
);
  logic [3:0] hold_r;
  logic [3:0] sel_r;
  logic [4:0] pin_cnt_r;
  // Outlasts a rising-edge completion, yet the falling edge still beats the watchdog
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_r <= 4'h0;
      sel_r <= 4'h0;
    end else if (go) begin
      hold_r <= 4'h9;
      sel_r <= idx;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end
  assign trig_in = (hold_r != 4'h0) ? (16'h0001 << sel_r) : 16'h0000;
  // Pins run free so unused sources still see activity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_cnt_r <= 5'h00;
    end else begin
      pin_cnt_r <= pin_cnt_r + 5'h01;
    end
  end
  assign clk_src_pins = pin_cnt_r;
endmodule
`default_nettype wire

/* File: sim/tsq_sequencer_bench.sv */
// Self-checking bench for the trigger sequencer top module.
// Assumes the peripheral model drives trig_in and clk_src_pins.
`timescale 1ns/100ps
`default_nettype none
module tsq_sequencer_bench;
  import tsq_pkg::*;
  logic clk = 1'b0;
  logic sys_rst;
  tsq_bus_req_t bus_req;
  logic [15:0] read_data;
  logic [15:0] trig_in;
  logic [4:0] clk_src_pins;
  logic [15:0] trig_out_r;
  logic [3:0] compare_sync_r;
  logic compare1_clk_r;
  logic [3:0] irq_out_r;
  logic step_irq_r;
  logic wdt_irq_r;
  logic go;
  logic [3:0] idx;
  logic rd_seen = 1'b0;
  logic [15:0] t_cnt = 16'h0;
  logic [15:0] t_val;
  logic [15:0] s_cnt = 16'h0;
  logic [15:0] s_val;
  logic [31:0] exp_q [7][$];
  logic [31:0] rnd;
  logic [7:0] prog [10] = '{8'h25, 8'h32, 8'h0f, 8'h10, 8'h11, 8'h21, 8'h45, 8'h08, 8'h23, 8'h11};
  int fails = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  tsq_sequencer u_tsq_sequencer (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .read_data(read_data),
    .trig_in(trig_in), .clk_src_pins(clk_src_pins), .trig_out_r(trig_out_r),
    .compare_sync_r(compare_sync_r), .compare1_clk_r(compare1_clk_r),
    .irq_out_r(irq_out_r), .step_irq_r(step_irq_r), .wdt_irq_r(wdt_irq_r)
  );
  tsq_periph_model u_tsq_periph_model (
    .clk(clk), .sys_rst(sys_rst), .go(go), .idx(idx),
    .trig_in(trig_in), .clk_src_pins(clk_src_pins)
  );

  task automatic cmp(input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask

  task automatic chk(input int k, input logic [31:0] seen);
    logic [31:0] e;
    e = (exp_q[k].size() == 0) ? 32'hdead0000 : exp_q[k].pop_front();
    cmp(seen, e);
  endtask

  task automatic note(input int k, input logic [31:0] e);
    exp_q[k].push_back(e);
  endtask

  function automatic int pending();
    int n;
    n = 0;
    for (int k = 0; k < 7; k++) n += exp_q[k].size();
    return n;
  endfunction

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    note(6, {16'h0, e});
    @(posedge clk);
    bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic pulse(input logic [3:0] i);
    @(posedge clk);
    go <= 1'b1;
    idx <= i;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // Bounded wait for a broadcast sync or a pulse on output one
  task automatic wait_evt();
    int i;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (compare_sync_r != 4'h0 || trig_out_r[1] === 1'b1) break;
    end
    if (i == 100) fails++;
  endtask

  task automatic settle();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (pending() == 0) break;
    end
    if (i == 400) fails++;
  endtask

  // Results are judged at the falling edge, where every output has settled
  always @(negedge clk) begin
    if (rd_seen) chk(6, {16'h0, read_data});
    rd_seen = bus_req.re;
    if (irq_out_r !== 4'h0) chk(1, {28'h0, irq_out_r});
    if (compare1_clk_r === 1'b1) chk(3, 32'h1);
    if (wdt_irq_r === 1'b1) chk(4, 32'h1);
    if (step_irq_r === 1'b1) chk(5, 32'h1);
    if (trig_out_r !== 16'h0) begin
      t_cnt = t_cnt + 16'h1;
      t_val = trig_out_r;
    end else if (t_cnt != 16'h0) begin
      chk(0, {t_cnt, t_val});
      t_cnt = 16'h0;
    end
    if (compare_sync_r !== 4'h0) begin
      s_cnt = s_cnt + 16'h1;
      s_val = {12'h0, compare_sync_r};
    end else if (s_cnt != 16'h0) begin
      chk(2, {s_cnt, s_val});
      s_cnt = 16'h0;
    end
  end

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    go = 1'b0;
    idx = 4'h0;
    void'($urandom(32'hc8d0a7aa));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[5:0], 16'h0000);
    rd(6'h08, 16'h0000);
    rnd = $urandom;
    wr(REG_CTRL, rnd[15:0]);
    rd(REG_CTRL, rnd[15:0] & CTRL_WMASK);
    wr(REG_BTE, rnd[31:16]);
    rd(REG_BTE, {11'h0, rnd[20:16]});
    wr(REG_CTRL, 16'h0022);
    wr(REG_BTE, 16'h001f);
    wr(REG_TLIM0, 16'h0005);
    wr(REG_CLIM0, 16'h0001);
    for (int i = 0; i < 10; i++) wr({QUE_PAGE, i[3:0]}, {8'h00, prog[i]});
    rd({QUE_PAGE, 4'h0}, 16'h0025);
    note(0, {16'h3, 16'h0020});
    note(1, 32'h4);
    note(2, {16'h3, 16'h000f});
    note(3, 32'h1);
    note(4, 32'h1);
    wr(REG_SETUP, 16'h0001);
    wr(REG_SETUP, 16'h0003);
    wait_evt();
    // Locked while running, so this write must be dropped
    wr(REG_BTE, 16'h0000);
    pulse(4'h0);
    settle();
    rd(REG_BTE, 16'h001f);
    rd(REG_STAT, 16'h0040);
    rd(REG_SETUP, 16'h0001);
    settle();
    note(0, {16'h3, 16'h0002});
    note(0, {16'h3, 16'h0002});
    note(0, {16'h3, 16'h0008});
    note(4, 32'h1);
    wr(REG_SETUP, 16'h0005);
    wr(REG_SETUP, 16'h0007);
    pulse(4'h1);
    wait_evt();
    cmp({31'h0, trig_in[1]}, 32'h0);
    settle();
    rd(REG_STAT, 16'h0090);
    settle();
    note(0, {16'h6, 16'h0020});
    note(5, 32'h1);
    wr(REG_SETUP, 16'h0000);
    wr(REG_CTRL, 16'h0122);
    wr(REG_SETUP, 16'h0009);
    wr(REG_SETUP, 16'h000b);
    settle();
    rd(REG_SETUP, 16'h0009);
    rd(REG_STAT, 16'h0010);
    settle();
    // Pin clock source at half rate; timer one, loop one, interrupt three
    wr(REG_SETUP, 16'h0000);
    wr(REG_CTRL, 16'h2001);
    wr(REG_CLIM1, 16'h0001);
    wr({QUE_PAGE, 4'h0}, 16'h0009);
    wr({QUE_PAGE, 4'h1}, 16'h002e);
    wr({QUE_PAGE, 4'h2}, 16'h0051);
    wr({QUE_PAGE, 4'h3}, 16'h0037);
    note(0, {16'h2, 16'h4000});
    note(0, {16'h2, 16'h4000});
    note(1, 32'h8);
    note(4, 32'h1);
    wr(REG_SETUP, 16'h0001);
    wr(REG_SETUP, 16'h0003);
    settle();
    rd(REG_STAT, 16'h0040);
    settle();
    stop_test();
  end
endmodule
`default_nettype wire
